// *** an_monitor_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts for the
 * auto-negotiation restart and progress monitor block.
 * Assumes a 32-bit Avalon-MM slave with word-aligned registers.
 */
`ifndef AN_MONITOR_MAP_SVH
`define AN_MONITOR_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AN_CONTROL_OFS        4'h0
`define AN_STATUS_OFS         4'h4
`define AN_QUICK_STATUS_OFS   4'h8
`define AN_ARB_STATE_OFS      4'hc

// ****************************************************************
// Control register fields
// ****************************************************************
`define AN_CTRL_RESTART_BIT   9
`define AN_CTRL_ENABLE_BIT    12
`define AN_CTRL_SOFT_RST_BIT  15
`define AN_CTRL_RESET_VAL     16'h1000

// ****************************************************************
// Status register fields
// ****************************************************************
`define AN_STAT_LINK_BIT      2
`define AN_STAT_DONE_BIT      5

// ****************************************************************
// Quick-status register fields
// ****************************************************************
`define AN_QS_SPEED_BIT       15
`define AN_QS_DUPLEX_BIT      14
`define AN_QS_PROG_HI         13
`define AN_QS_PROG_LO         11
`define AN_QS_DONE_BIT        4
`define AN_QS_LINK_BIT        0

// ****************************************************************
// Progress codes and timing
// ****************************************************************
`define AN_CODE_IDLE          4'h0
`define AN_CODE_MAX_RUN       4'h8
`define AN_CODE_DONE          4'hf
// Held after completion: complete flag set, three progress bits zero
`define AN_CODE_LINKED        4'h8
`define AN_TIMEOUT_MS         500
`define AN_CLK_MHZ            250
`define AN_TIMEOUT_CYCLES     (`AN_TIMEOUT_MS * 1000 * `AN_CLK_MHZ)

`endif

// *** an_monitor_pkg.sv ***
/*
 * Types shared by the auto-negotiation restart and progress monitor.
 * Assumes the constants of an_monitor_map.svh.
 */
package an_monitor_pkg;

	// Arbitration supervisor states
	typedef enum logic [1:0] {
		arb_idle    = 2'b00,
		arb_running = 2'b01,
		arb_done    = 2'b10
	} arb_phase_e;

	// Link result from the arbitration core
	typedef struct packed {
		logic link_up;
		logic speed_100;
		logic full_duplex;
		logic link_fail;
	} link_result_s;

	typedef logic [3:0] progress_code_t;

endpackage

// *** autoneg_restart_progress_monitor.sv ***
/*
 * Auto-negotiation restart control and progress monitor with an Avalon-MM
 * register slave: control, status, quick-status and arbitration state views.
 * Assumes the arbitration core supplies its 4-bit state and link result
 * synchronously to core_clk, and restarts itself on restart_pulse.
 */
// Summary of operation
// - Restart returns arbitration logic to default, like reset, and restarts the run timer.
// - Restart keeps the latched progress code unchanged.
// - After restart only reads, reset or higher states change progress.
// - After completion only quick-status reads or reset alter progress.
// - A link failure restarts negotiation automatically.
// - Software writes restart bit one; it clears itself.
// - Enable bit toggling one-zero-one restarts negotiation outside hardware mode.
// - Select pin high-low-high restarts negotiation in hardware mode.
// - Negotiation normally completes under 500 ms.
// - Quick-status bit 15 gives speed, bit 14 duplex.
// - Quick-status bit 0 mirrors link, bit 4 completion.
// - Progress code bits are 17.4, 17.13, 17.12, 17.11.
// - Progress codes are 0 through 8, or F.
// - Apart from quick-status reads and reset, held code updates only when arbitration state exceeds it.
// - A quick-status read loads the present arbitration state, or code 8 once complete.
// - A read returns the value held before that read.
// - First read after completion gives complete one, progress 111.
// - Later reads give complete one, progress 000 while linked.
// - Any reset clears monitor and progress bits to zero.
// - Completion sets status and quick-status complete bits.
`timescale 1ns/10ps
`include "an_monitor_map.svh"

module autoneg_restart_progress_monitor #(
	parameter int unsigned TIMEOUT_CYCLES = `AN_TIMEOUT_CYCLES
) (
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	input  wire logic                          clk_en,
	input  wire logic                          hardware_mode,
	input  wire logic                          negotiation_select_pin,
	input  wire logic [3:0]                    arb_state,
	input  wire an_monitor_pkg::link_result_s  link_result,
	input  wire logic [3:0]                    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	output logic                               avs_response_err,
	output logic                               restart_pulse,
	output logic                               arb_reset,
	output logic                               negotiation_timeout
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Address match used by every register decode
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Clamp to a legal progress code so no stray value is latched
	function automatic an_monitor_pkg::progress_code_t legal(input logic [3:0] code);
		if (code <= `AN_CODE_MAX_RUN || code == `AN_CODE_DONE) begin
			legal = code;
		end else begin
			legal = `AN_CODE_IDLE;
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	an_monitor_pkg::arb_phase_e     phase;
	an_monitor_pkg::arb_phase_e     next_phase;
	an_monitor_pkg::progress_code_t progress;
	an_monitor_pkg::progress_code_t next_progress;
	logic                           enable_bit;
	logic                           restart_bit;
	logic                           soft_reset;
	logic                           enable_seen_low;
	logic                           pin_prev;
	logic                           pin_seen_low;
	logic                           link_fail_prev;
	logic                           read_done;
	logic [31:0]                    timer;
	logic [31:0]                    next_timer;

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	// Reads take two cycles: data latched first, ack second
	wire an_monitor_pkg::progress_code_t present_code = legal(arb_state);
	wire rd_ctrl     = hit(avs_address, `AN_CONTROL_OFS);
	wire rd_stat     = hit(avs_address, `AN_STATUS_OFS);
	wire rd_quick    = hit(avs_address, `AN_QUICK_STATUS_OFS);
	wire rd_arb      = hit(avs_address, `AN_ARB_STATE_OFS);
	wire mapped      = rd_ctrl | rd_stat | rd_quick | rd_arb;
	wire wr_ctrl     = avs_write & rd_ctrl & avs_byteenable[1] & clk_en;
	wire read_take   = avs_read & ~read_done & clk_en;
	wire quick_take  = read_take & rd_quick;
	wire run_done    = (phase == an_monitor_pkg::arb_done);
	wire [15:0] ctrl_reset = `AN_CTRL_RESET_VAL;

	// Restart triggers
	wire wr_restart  = wr_ctrl & avs_writedata[`AN_CTRL_RESTART_BIT];
	wire wr_enable   = wr_ctrl ? avs_writedata[`AN_CTRL_ENABLE_BIT] : enable_bit;
	wire enable_rise = ~hardware_mode & enable_seen_low & wr_enable & ~enable_bit;
	wire pin_rise    = hardware_mode & pin_seen_low & negotiation_select_pin & ~pin_prev;
	wire fail_rise   = link_result.link_fail & ~link_fail_prev;
	wire soft_restart = ~hardware_mode & restart_bit;
	wire any_restart = soft_restart | enable_rise | pin_rise | fail_rise;
	wire any_reset   = reset | soft_reset;

	assign avs_waitrequest = avs_read & ~read_done;
	assign restart_pulse   = any_restart & clk_en;
	assign arb_reset       = any_reset | any_restart;

	// ****************************************************************
	// Read data assembly
	// ****************************************************************

	// Quick-status view uses the held code, captured before this read loads it
	wire [15:0] quick_word = {
		link_result.speed_100,
		link_result.full_duplex,
		progress[2:0],
		6'h00,
		progress[3],
		3'h0,
		link_result.link_up
	};
	wire [15:0] ctrl_word = {soft_reset, 2'h0, enable_bit, 2'h0, restart_bit, 9'h000};
	wire [15:0] stat_word = {10'h000, run_done, 2'h0, link_result.link_up, 2'h0};
	wire [15:0] arb_word  = {12'h000, present_code};
	wire [15:0] read_mux  = rd_quick ? quick_word :
	                        rd_stat  ? stat_word :
	                        rd_ctrl  ? ctrl_word :
	                        rd_arb   ? arb_word : 16'h0000;

	// ****************************************************************
	// Progress monitor next value
	// ****************************************************************

	// Read load wins; otherwise only a larger state is latched
	// Once complete, a read leaves the complete flag with zero progress bits
	always_comb begin
		next_progress = progress;
		if (quick_take) begin
			next_progress = run_done ? `AN_CODE_LINKED : present_code;
		end else if (run_done) begin
			next_progress = progress;
		end else if (present_code > progress) begin
			next_progress = present_code;
		end
	end

	// ****************************************************************
	// Arbitration supervisor
	// ****************************************************************

	// Tracks run and completion; a restart drops back to running
	always_comb begin
		next_phase = phase;
		next_timer = timer;
		case (phase)
			an_monitor_pkg::arb_idle: begin
				if (enable_bit || hardware_mode) begin
					next_phase = an_monitor_pkg::arb_running;
					next_timer = 32'h0000_0000;
				end
			end
			an_monitor_pkg::arb_running: begin
				if (present_code == `AN_CODE_DONE) begin
					next_phase = an_monitor_pkg::arb_done;
				end else if (timer < TIMEOUT_CYCLES) begin
					next_timer = timer + 32'h0000_0001;
				end
			end
			an_monitor_pkg::arb_done: begin
				if (present_code != `AN_CODE_DONE) begin
					next_phase = an_monitor_pkg::arb_running;
					next_timer = 32'h0000_0000;
				end
			end
			default: begin
				next_phase = an_monitor_pkg::arb_idle;
			end
		endcase
		if (any_restart) begin
			next_phase = an_monitor_pkg::arb_running;
			next_timer = 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Progress code survives restarts, cleared only by reset
	always_ff @(posedge core_clk) begin
		if (any_reset) begin
			progress <= `AN_CODE_IDLE;
		end else if (clk_en) begin
			progress <= next_progress;
		end
	end

	// Supervisor and timeout
	always_ff @(posedge core_clk) begin
		if (any_reset) begin
			phase               <= an_monitor_pkg::arb_idle;
			timer               <= 32'h0000_0000;
			negotiation_timeout <= 1'b0;
		end else if (clk_en) begin
			phase               <= next_phase;
			timer               <= next_timer;
			negotiation_timeout <= (next_timer >= TIMEOUT_CYCLES);
		end
	end

	// Control bits; restart self-clears the cycle after it acts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			enable_bit  <= ctrl_reset[`AN_CTRL_ENABLE_BIT];
			restart_bit <= 1'b0;
			soft_reset  <= 1'b0;
		end else if (clk_en) begin
			enable_bit  <= wr_enable;
			restart_bit <= wr_restart & ~restart_bit;
			soft_reset  <= wr_ctrl & avs_writedata[`AN_CTRL_SOFT_RST_BIT] & ~soft_reset;
		end
	end

	// Edge trackers for the enable bit, pin and link failure
	always_ff @(posedge core_clk) begin
		if (any_reset) begin
			enable_seen_low <= 1'b0;
			pin_prev        <= 1'b0;
			pin_seen_low    <= 1'b0;
			link_fail_prev  <= 1'b0;
		end else if (clk_en) begin
			if (enable_bit && !wr_enable) begin
				enable_seen_low <= 1'b1;
			end else if (enable_rise) begin
				enable_seen_low <= 1'b0;
			end
			pin_prev <= negotiation_select_pin;
			if (pin_prev && !negotiation_select_pin) begin
				pin_seen_low <= 1'b1;
			end else if (pin_rise) begin
				pin_seen_low <= 1'b0;
			end
			link_fail_prev <= link_result.link_fail;
		end
	end

	// Read data registered; the progress load lands in the same edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			avs_readdata     <= 32'h0000_0000;
			avs_response_err <= 1'b0;
			read_done        <= 1'b0;
		end else if (clk_en) begin
			read_done <= read_take;
			if (read_take) begin
				avs_readdata     <= {16'h0000, read_mux};
				avs_response_err <= ~mapped;
			end else if (avs_write) begin
				avs_response_err <= ~mapped;
			end
		end
	end

endmodule

// *** autoneg_restart_progress_monitor_sva.sv ***
/*
 * Port-level checker for the auto-negotiation restart and progress monitor.
 * Assumes one clock domain, core_clk, with reset synchronous and active high.
 */
`timescale 1ns/10ps
module autoneg_restart_progress_monitor_sva (
	input wire logic				core_clk,
	input wire logic				reset,
	input wire logic				clk_en,
	input wire logic				hardware_mode,
	input wire logic				negotiation_select_pin,
	input wire logic [3:0]				arb_state,
	input wire an_monitor_pkg::link_result_s	link_result,
	input wire logic [3:0]				avs_address,
	input wire logic				avs_read,
	input wire logic				avs_write,
	input wire logic [31:0]				avs_writedata,
	input wire logic [3:0]				avs_byteenable,
	input wire logic [31:0]				avs_readdata,
	input wire logic				avs_waitrequest,
	input wire logic				avs_response_err,
	input wire logic				restart_pulse,
	input wire logic				arb_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [3:0]			snap;
	logic				snap_ok;
	an_monitor_pkg::link_result_s	lr_q;
	wire qs_take = avs_read && avs_waitrequest && clk_en && avs_address == 4'h8;
	// Remember what a read loaded; any state change spoils the prediction
	// A read at completion loads the linked code, so it predicts nothing
	always_ff @(posedge core_clk) begin
		lr_q <= link_result;
		if (reset) begin
			snap_ok <= 1'b0;
		end else if (qs_take) begin
			snap <= arb_state;
			snap_ok <= (arb_state != 4'hf);
		end else if (arb_state != snap) begin
			snap_ok <= 1'b0;
		end
	end
	// ****************************************************************
	// Restart triggers
	// ****************************************************************
	sequence en_wr(bit v);
		avs_write && clk_en && !hardware_mode && avs_address == 4'h0 && avs_byteenable[1]
			&& avs_writedata[12] == v && !avs_writedata[15];
	endsequence
	sequence pin_cycle;
		hardware_mode && $fell(negotiation_select_pin) ##[1:20] hardware_mode && $rose(negotiation_select_pin);
	endsequence
	restart_arb_a: assert property (restart_pulse |-> arb_reset) else $error("restart without arb reset");
	link_fail_a: assert property (clk_en && $rose(link_result.link_fail) |-> ##[0:3] restart_pulse)
		else $error("link failure did not restart");
	sw_restart_a: assert property (en_wr(1'b1) and avs_writedata[9] |-> ##[0:3] restart_pulse)
		else $error("restart bit did not restart");
	en_toggle_a: assert property (en_wr(1'b0) ##[1:20] en_wr(1'b1) |-> ##[0:3] restart_pulse)
		else $error("enable toggle did not restart");
	pin_restart_a: assert property (pin_cycle |-> ##[0:3] restart_pulse) else $error("pin toggle no restart");
	// ****************************************************************
	// Read side
	// ****************************************************************
	read_wait_a: assert property (avs_read && avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("read answer late");
	read_old_a: assert property (qs_take && snap_ok |=> {avs_readdata[4], avs_readdata[13:11]} == $past(snap))
		else $error("read gave wrong progress");
	qs_mirror_a: assert property (qs_take |=> avs_readdata[15] == lr_q.speed_100
		&& avs_readdata[14] == lr_q.full_duplex && avs_readdata[0] == lr_q.link_up) else $error("link fields wrong");
	reset_clear_a: assert property (disable iff (1'b0) reset |=> avs_readdata == 32'h0 && !avs_response_err)
		else $error("reset left read data");
endmodule

bind autoneg_restart_progress_monitor autoneg_restart_progress_monitor_sva chk_u (.core_clk(core_clk),
	.reset(reset), .clk_en(clk_en), .hardware_mode(hardware_mode), .negotiation_select_pin(negotiation_select_pin),
	.arb_state(arb_state), .link_result(link_result), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
	.restart_pulse(restart_pulse), .arb_reset(arb_reset));

// *** arb_core_model.sv ***
/*
 * Behavioural arbitration core: walks its state code to a goal set by the bench.
 * Assumes arb_reset from the monitor is sampled on core_clk.
 */
`timescale 1ns/10ps
module arb_core_model (
	input wire logic				core_clk,
	input wire logic				arb_reset,
	input wire logic				slow,
	input wire an_monitor_pkg::progress_code_t	goal,
	output an_monitor_pkg::progress_code_t		arb_state
);
	// Slow mode climbs one code a cycle, so the monitor sees every state
	always_ff @(posedge core_clk) begin
		if (arb_reset) begin
			arb_state <= 4'h0;
		end else if (!slow || arb_state > goal) begin
			arb_state <= goal;
		end else if (arb_state < goal) begin
			arb_state <= arb_state + 4'h1;
		end
	end
endmodule

// *** autoneg_restart_progress_monitor_tb.sv ***
/*
 * Self-checking bench for the restart and progress monitor block.
 * Assumes the checker binds itself and arb_core_model plays the arbitration core.
 */
`timescale 1ns/10ps
module autoneg_restart_progress_monitor_tb;
	logic				core_clk = 1'b0;
	logic				reset = 1'b1;
	logic				clk_en = 1'b1;
	logic				negotiation_timeout;
	logic				hardware_mode = 1'b0;
	logic				negotiation_select_pin = 1'b1;
	logic				slow = 1'b0;
	an_monitor_pkg::progress_code_t	goal = 4'h0;
	an_monitor_pkg::progress_code_t	arb_state;
	an_monitor_pkg::link_result_s	link_result = 4'h0;
	logic [3:0]			avs_address = 4'h0;
	logic				avs_read = 1'b0;
	logic				avs_write = 1'b0;
	logic [31:0]			avs_writedata = 32'h0;
	logic [31:0]			avs_readdata;
	logic				avs_waitrequest;
	logic				avs_response_err;
	logic				restart_pulse;
	logic				arb_reset;
	logic [31:0]			q;
	int				bad_count = 0;
	int				samples_checked = 0;
	int				pulses = 0;
	int				p0;
	always #2 core_clk = ~core_clk;
	// Count restarts away from the sampling edge
	always @(negedge core_clk) begin
		if (restart_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	autoneg_restart_progress_monitor #(.TIMEOUT_CYCLES(50)) dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.hardware_mode(hardware_mode), .negotiation_select_pin(negotiation_select_pin), .arb_state(arb_state),
		.link_result(link_result), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .restart_pulse(restart_pulse),
		.arb_reset(arb_reset), .negotiation_timeout(negotiation_timeout));
	arb_core_model model_u (.core_clk(core_clk), .arb_reset(arb_reset), .slow(slow), .goal(goal),
		.arb_state(arb_state));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic give_verdict;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			$display("BAD %0t got %h want %h", $time, s, e);
			bad_count++;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Request stays up until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic wt;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		wt = 1'b1;
		for (n = 0; n < 40 && wt !== 1'b0; n++) begin
			@(posedge core_clk);
			wt = avs_waitrequest;
			q = avs_readdata;
		end
		if (wt !== 1'b0) begin
			$display("BAD %0t bus hung", $time);
			bad_count++;
			give_verdict();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h1000);
		bus(1'b0, 4'h6, 32'h0);
		chk(32'(avs_response_err), 32'h1);
	endtask
	task automatic t_progress;
		goal <= 4'h3;
		idle(4);
		goal <= 4'h1;
		idle(4);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h3);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h1);
		slow <= 1'b1;
		goal <= 4'h5;
		idle(8);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h5);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h5);
		slow <= 1'b0;
		goal <= 4'ha;
		idle(2);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic t_restart;
		goal <= 4'h6;
		idle(4);
		goal <= 4'h2;
		idle(4);
		p0 = pulses;
		bus(1'b1, 4'h0, 32'h1200);
		idle(4);
		chk(32'(pulses - p0), 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h1000);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h6);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h0, 32'h1000);
		idle(4);
		chk(32'(pulses - p0), 32'h2);
	endtask
	task automatic t_triggers;
		p0 = pulses;
		hardware_mode <= 1'b1;
		idle(2);
		bus(1'b1, 4'h0, 32'h1200);
		idle(4);
		chk(32'(pulses - p0), 32'h0);
		negotiation_select_pin <= 1'b0;
		idle(4);
		negotiation_select_pin <= 1'b1;
		idle(4);
		chk(32'(pulses - p0), 32'h1);
		hardware_mode <= 1'b0;
		link_result.link_fail <= 1'b1;
		idle(4);
		chk(32'(pulses - p0), 32'h2);
		link_result.link_fail <= 1'b0;
	endtask
	// Frozen clock enable, run timeout, restart clearing it, soft reset
	task automatic t_freeze;
		p0 = pulses;
		idle(60);
		chk(32'(negotiation_timeout), 32'h1);
		clk_en <= 1'b0;
		goal <= 4'h7;
		bus(1'b1, 4'h0, 32'h1200);
		avs_address <= 4'h8;
		avs_read <= 1'b1;
		idle(3);
		chk(32'(avs_waitrequest), 32'h1);
		chk(32'(pulses - p0), 32'h0);
		avs_read <= 1'b0;
		clk_en <= 1'b1;
		idle(1);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h7);
		bus(1'b1, 4'h0, 32'h1200);
		idle(2);
		chk(32'(negotiation_timeout), 32'h0);
		chk(32'(pulses - p0), 32'h1);
		goal <= 4'h0;
		bus(1'b1, 4'h0, 32'h9000);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h0);
	endtask
	task automatic t_done;
		link_result <= 4'hc;
		goal <= 4'hf;
		idle(6);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'hf);
		chk(32'({q[15], q[14], q[0]}), 32'h5);
		bus(1'b0, 4'h4, 32'h0);
		chk(q & 32'h24, 32'h24);
		bus(1'b0, 4'h8, 32'h0);
		chk(32'({q[4], q[13:11]}), 32'h8);
		goal <= 4'h0;
		reset <= 1'b1;
		idle(1);
		reset <= 1'b0;
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h8001);
	endtask
	initial begin
		idle(4);
		reset <= 1'b0;
		t_reset();
		t_progress();
		t_restart();
		t_triggers();
		t_freeze();
		t_done();
		give_verdict();
	end
endmodule
